/* File: pkg/debug_event_pkg.sv */
/*
 * Constants, state type and register layout for the debug event router.
 * Assumes a single 25 MHz processor clock and an AXI4-Lite register port.
 */
// Operation
// R1: External debug requests count only while running; ignored when already halted.
// R2: An external request that becomes a debug event sets the external flag.
// R3: Entering the halted state raises a cross-halt output mirroring the halted status.
// R4: While halted, an external restart request resumes execution.
// R5: Restart requests arriving while running are ignored.
// R6: Local reset leaves the halted state; enable fields clear on power-on reset only.
// R7: Halting debug plus reset catch enabled: halt and set halt request after reset.
// R8: With halting debug enabled any debug event halts and sets halt request.
// R9: Halting debug is off when its enable is 0 or authentication forbids it; reset catch here needs only the enable.
// R10: Halting off, monitor on: monitor exception only if its priority exceeds current.
// R11: Low monitor priority: breakpoint instruction escalates to a hard fault.
// R12: Low monitor priority: breakpoint unit hit escalates to hard fault here.
// R13: Low monitor priority: watchpoint and external request events are dropped.
// R14: An event raising the monitor exception sets the monitor pending bit.
// R15: Software may set monitor pending anytime; it is taken regardless of monitor enable.
// R16: Halting and monitor both off: breakpoints hard fault, other events ignored.
// R17: Breakpoint in NMI or hard fault handler without halting debug locks up.
// R18: Each event kind has a write-one-to-clear flag set when it halts or traps.
// R19: Vector catch only halts; other event kinds support halt and monitor handling.
// R20: External request not halting, monitor enabled with priority, sets monitor pending.
// R21: External request and restart are levels, synchronised, held until answered.
package debug_event_pkg;
    // --------------------------------------------------------------
    // Register byte offsets
    // --------------------------------------------------------------
    localparam logic [3:0] OFS_HALT_CTRL = 4'h0;  // halt_ctrl_status_reg
    localparam logic [3:0] OFS_MON_CTRL  = 4'h4;  // exc_monitor_ctrl_reg
    localparam logic [3:0] OFS_FAULT_ST  = 4'h8;  // debug_fault_status_reg
    // halt_ctrl_status_reg fields
    localparam int BIT_HALT_DBG_EN   = 0;
    localparam int BIT_HALT_REQ      = 1;
    localparam int BIT_HALTED_STATUS = 17;
    // exc_monitor_ctrl_reg fields
    localparam int BIT_RST_VC_EN  = 0;
    localparam int BIT_MON_ENA    = 16;
    localparam int BIT_MON_PENDING = 17;
    // debug_fault_status_reg fields
    localparam int FLAG_HALTED = 0;
    localparam int FLAG_BRK    = 1;
    localparam int FLAG_WATCH  = 2;
    localparam int FLAG_VECT   = 3;
    localparam int FLAG_EXT    = 4;
    localparam int NUM_FLAGS   = 5;
    localparam logic [4:0] FLAGS_RESET = 5'h00;
    // Bus response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Core debug state, Gray coded run -> halt -> lockup
    typedef enum logic [1:0] {
        ST_RUN  = 2'h0,
        ST_HALT = 2'h1,
        ST_LOCK = 2'h3
    } core_state_t;
endpackage

/* File: rtl/debug_event_router.sv */
/*
 * Debug event router: routes debug events to halt, monitor exception,
 * hard fault or lockup, holds the debug control/status registers and
 * serves them over AXI4-Lite.
 * Assumes all inputs synchronous to aclk except the two external request
 * levels, which are resynchronised here. Priorities are urgency levels:
 * a larger number is more urgent.
 */
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module debug_event_router
    import debug_event_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        por_resetn,
    input  wire logic        clk_en,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [31:0] s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    input  wire logic        ext_debug_request_in,
    input  wire logic        ext_restart_request_in,
    input  wire logic        auth_halt_allowed,
    input  wire logic [7:0]  exec_priority,
    input  wire logic [7:0]  monitor_priority,
    input  wire logic        in_nmi_or_hardfault,
    input  wire logic        evt_internal_halt,
    input  wire logic        evt_brk_instr,
    input  wire logic        evt_brk_unit,
    input  wire logic        evt_watchpoint,
    input  wire logic        evt_vector_catch,
    input  wire logic        monitor_taken,
    output logic             halted,
    output logic             monitor_request,
    output logic             hard_fault_req,
    output logic             lockup
);
    // --------------------------------------------------------------
    // Declarations
    // --------------------------------------------------------------
    core_state_t           state_r, state_nxt;
    logic                  halting_debug_enable, reset_vector_catch_enable, monitor_enable;
    logic                  monitor_pending, halt_req_r, rst_seen_r;
    logic [NUM_FLAGS-1:0]  flags_r, flags_set;
    logic                  edbg_meta_r, edbg_sync_r, rst_meta_r, rst_sync_r;
    logic                  aw_got_r, w_got_r;
    logic [3:0]            aw_ofs_r;
    logic [31:0]           wdata_r;
    logic [3:0]            wstrb_r;
    logic                  halt_en, mon_ok, running, ext_evt, brk_any, any_evt;
    logic                  reset_catch, enter_halt, to_monitor, to_lockup, to_fault;
    logic                  leave_halt, wr_fire, sw_halt_clear;
    logic                  mon_set, mon_clr_sw, mon_set_sw;

    // Register index decode shared by read and write paths
    function automatic logic [1:0] reg_sel(input logic [31:0] addr);
        if (addr[31:4] != 28'h0000000 || addr[1:0] != 2'h0) begin
            reg_sel = 2'h3;
        end else if (addr[3:0] == OFS_HALT_CTRL) begin
            reg_sel = 2'h0;
        end else if (addr[3:0] == OFS_MON_CTRL) begin
            reg_sel = 2'h1;
        end else if (addr[3:0] == OFS_FAULT_ST) begin
            reg_sel = 2'h2;
        end else begin
            reg_sel = 2'h3;
        end
    endfunction

    // --------------------------------------------------------------
    // External request synchronisers
    // --------------------------------------------------------------
    // R21: level inputs, two flops each
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            edbg_meta_r <= 1'b0;
            edbg_sync_r <= 1'b0;
            rst_meta_r  <= 1'b0;
            rst_sync_r  <= 1'b0;
        end else if (clk_en) begin
            edbg_meta_r <= ext_debug_request_in;
            edbg_sync_r <= edbg_meta_r;
            rst_meta_r  <= ext_restart_request_in;
            rst_sync_r  <= rst_meta_r;
        end
    end

    // --------------------------------------------------------------
    // Event routing
    // --------------------------------------------------------------
    // Events are resolved in one cycle; a held external level re-fires
    // monitor pending each cycle, which is harmless as the bit is sticky.
    always_comb begin
        running     = (state_r == ST_RUN);
        // R9: halting needs enable and authentication
        halt_en     = halting_debug_enable & auth_halt_allowed;
        // R10: monitor only above current priority
        mon_ok      = monitor_enable & (monitor_priority > exec_priority);
        // R1: external request counts only while running
        ext_evt     = running & edbg_sync_r;
        brk_any     = running & (evt_brk_instr | evt_brk_unit);
        any_evt     = running & (evt_internal_halt | evt_brk_instr | evt_brk_unit |
                      evt_watchpoint | evt_vector_catch | edbg_sync_r);
        // R7: reset catch at first enabled edge after local reset
        reset_catch = !rst_seen_r & halting_debug_enable & reset_vector_catch_enable;
        // R8: any event halts when halting is enabled
        enter_halt  = (halt_en & any_evt) | reset_catch;
        // R17: breakpoint in NMI or hard fault handler locks up
        to_lockup   = !halt_en & brk_any & in_nmi_or_hardfault;
        // R19: vector catch never reaches the monitor
        to_monitor  = !halt_en & !to_lockup & mon_ok & running &
                      (evt_internal_halt | evt_brk_instr | evt_brk_unit |
                       evt_watchpoint | edbg_sync_r);
        // R11 R12 R16: breakpoints escalate, watch and external drop (R13)
        to_fault    = !halt_en & !to_lockup & !mon_ok & brk_any;
    end

    // Flags set only by events that halt or trap
    always_comb begin
        flags_set = FLAGS_RESET;
        if (enter_halt | to_monitor) begin
            // R18: one flag per event kind
            flags_set[FLAG_HALTED] = running & evt_internal_halt;
            flags_set[FLAG_BRK]    = brk_any;
            flags_set[FLAG_WATCH]  = running & evt_watchpoint;
            // R2: external event flag
            flags_set[FLAG_EXT]    = ext_evt;
        end
        if (enter_halt) begin
            flags_set[FLAG_VECT]   = (running & evt_vector_catch) | reset_catch;
        end
    end

    // --------------------------------------------------------------
    // Core debug state
    // --------------------------------------------------------------
    assign wr_fire       = aw_got_r & w_got_r & !s_axi_bvalid;
    assign sw_halt_clear = wr_fire & (reg_sel({28'h0000000, aw_ofs_r}) == 2'h0) &
                           wstrb_r[0] & !wdata_r[BIT_HALT_REQ];
    // R4: restart or halt request cleared resumes; R5: restart ignored when running
    assign leave_halt    = (state_r == ST_HALT) & (rst_sync_r | sw_halt_clear) & !reset_catch;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (to_lockup) begin
                    state_nxt = ST_LOCK;
                end else if (enter_halt) begin
                    state_nxt = ST_HALT;
                end
            end
            ST_HALT: begin
                if (leave_halt) begin
                    state_nxt = ST_RUN;
                end
            end
            default: begin
                state_nxt = ST_LOCK;
            end
        endcase
    end

    // R6: local reset forces the run state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r        <= ST_RUN;
            halted         <= 1'b0;
            lockup         <= 1'b0;
            hard_fault_req <= 1'b0;
            rst_seen_r     <= 1'b0;
        end else if (clk_en) begin
            state_r        <= state_nxt;
            // R3: cross-halt output mirrors the halted status
            halted         <= (state_nxt == ST_HALT);
            lockup         <= (state_nxt == ST_LOCK);
            hard_fault_req <= to_fault;
            rst_seen_r     <= 1'b1;
        end
    end

    // Halt request bit follows entry and software writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            halt_req_r <= 1'b0;
        end else if (clk_en) begin
            if (enter_halt) begin
                // R8: entry sets the halt request bit
                halt_req_r <= 1'b1;
            end else if (leave_halt) begin
                halt_req_r <= 1'b0;
            end else if (wr_fire & (reg_sel({28'h0000000, aw_ofs_r}) == 2'h0) & wstrb_r[0]) begin
                halt_req_r <= wdata_r[BIT_HALT_REQ];
            end
        end
    end

    // --------------------------------------------------------------
    // Power-on-only control fields
    // --------------------------------------------------------------
    // R6: these survive a local reset so reset catch can work
    always_ff @(posedge aclk) begin
        if (!por_resetn) begin
            halting_debug_enable      <= 1'b0;
            reset_vector_catch_enable <= 1'b0;
            monitor_enable            <= 1'b0;
        end else if (clk_en & wr_fire) begin
            if (reg_sel({28'h0000000, aw_ofs_r}) == 2'h0 && wstrb_r[0]) begin
                halting_debug_enable <= wdata_r[BIT_HALT_DBG_EN];
            end
            if (reg_sel({28'h0000000, aw_ofs_r}) == 2'h1) begin
                if (wstrb_r[0]) begin
                    reset_vector_catch_enable <= wdata_r[BIT_RST_VC_EN];
                end
                if (wstrb_r[2]) begin
                    monitor_enable <= wdata_r[BIT_MON_ENA];
                end
            end
        end
    end

    // --------------------------------------------------------------
    // Monitor pending and fault status flags
    // --------------------------------------------------------------
    // R14 R20: trapping events set pending; hardware set beats any clear
    assign mon_set    = to_monitor;
    assign mon_set_sw = wr_fire & (reg_sel({28'h0000000, aw_ofs_r}) == 2'h1) &
                        wstrb_r[2] & wdata_r[BIT_MON_PENDING];
    assign mon_clr_sw = wr_fire & (reg_sel({28'h0000000, aw_ofs_r}) == 2'h1) &
                        wstrb_r[2] & !wdata_r[BIT_MON_PENDING];
    // R15: pending drives the request whatever the monitor enable
    always_ff @(posedge aclk) begin
        if (!por_resetn) begin
            monitor_pending <= 1'b0;
            monitor_request <= 1'b0;
        end else if (clk_en) begin
            if (mon_set | mon_set_sw) begin
                monitor_pending <= 1'b1;
                monitor_request <= 1'b1;
            end else if (mon_clr_sw | monitor_taken) begin
                monitor_pending <= 1'b0;
                monitor_request <= 1'b0;
            end
        end
    end

    // R18: write one to clear, set wins
    always_ff @(posedge aclk) begin
        if (!por_resetn) begin
            flags_r <= FLAGS_RESET;
        end else if (clk_en) begin
            if (wr_fire && reg_sel({28'h0000000, aw_ofs_r}) == 2'h2 && wstrb_r[0]) begin
                flags_r <= (flags_r & ~wdata_r[NUM_FLAGS-1:0]) | flags_set;
            end else begin
                flags_r <= flags_r | flags_set;
            end
        end
    end

    // --------------------------------------------------------------
    // AXI4-Lite write channel
    // --------------------------------------------------------------
    // Address and data are caught independently; response after both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r      <= 1'b0;
            w_got_r       <= 1'b0;
            aw_ofs_r      <= 4'h0;
            wdata_r       <= 32'h00000000;
            wstrb_r       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else if (clk_en) begin
            s_axi_awready <= !aw_got_r & !s_axi_awready & !s_axi_bvalid;
            s_axi_wready  <= !w_got_r & !s_axi_wready & !s_axi_bvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                aw_got_r <= 1'b1;
                aw_ofs_r <= (s_axi_awaddr[31:4] == 28'h0000000) ? s_axi_awaddr[3:0] : 4'hf;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (reg_sel({28'h0000000, aw_ofs_r}) == 2'h3) ? RESP_SLVERR
                                                                          : RESP_OKAY;
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // --------------------------------------------------------------
    // AXI4-Lite read channel
    // --------------------------------------------------------------
    // Register status is sampled at the address handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (clk_en) begin
            s_axi_arready <= !s_axi_arready & !s_axi_rvalid;
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= RESP_OKAY;
                s_axi_rdata   <= 32'h00000000;
                case (reg_sel(s_axi_araddr))
                    2'h0: begin
                        s_axi_rdata[BIT_HALT_DBG_EN]   <= halting_debug_enable;
                        s_axi_rdata[BIT_HALT_REQ]      <= halt_req_r;
                        s_axi_rdata[BIT_HALTED_STATUS] <= (state_r == ST_HALT);
                    end
                    2'h1: begin
                        s_axi_rdata[BIT_RST_VC_EN] <= reset_vector_catch_enable;
                        s_axi_rdata[BIT_MON_ENA]     <= monitor_enable;
                        s_axi_rdata[BIT_MON_PENDING] <= monitor_pending;
                    end
                    2'h2: begin
                        s_axi_rdata[NUM_FLAGS-1:0] <= flags_r;
                    end
                    default: begin
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || !por_resetn);
    sequence s_ext_while_running;
        clk_en && running && edbg_sync_r && halt_en && !to_lockup;
    endsequence
    sequence s_halted_ext;
        clk_en && state_r == ST_HALT && edbg_sync_r && !rst_sync_r && !sw_halt_clear;
    endsequence
    a_ext_halts_core: assert property (s_ext_while_running |=> halted && flags_r[FLAG_EXT]) // R2
        else $error("external request did not halt and flag");
    a_halted_ignores_ext: assert property (s_halted_ext |=> halted && !hard_fault_req) // R1
        else $error("external request acted while halted");
    a_cross_halt_mirror: assert property (halted == (state_r == ST_HALT)) // R3
        else $error("cross-halt output differs from halted status");
    a_restart_resumes: assert property (clk_en && state_r == ST_HALT && rst_sync_r // R4
        && !reset_catch |=> !halted && !halt_req_r)
        else $error("restart did not leave halted state");
    a_restart_run_noop: assert property (clk_en && running && rst_sync_r && !any_evt // R5
        && !reset_catch |=> state_r == ST_RUN)
        else $error("restart changed running state");
    a_mon_pending_set: assert property (clk_en && to_monitor // R14
        |=> monitor_pending && monitor_request)
        else $error("monitor trap did not set pending");
    a_low_prio_fault: assert property (clk_en && running && evt_brk_instr && !halt_en // R11
        && !mon_ok && !in_nmi_or_hardfault |=> hard_fault_req)
        else $error("breakpoint did not escalate to hard fault");
    // Software writes and a taken exception may move pending legally
    a_watch_dropped: assert property (clk_en && running && !halt_en && !mon_ok // R13
        && evt_watchpoint && !brk_any && !edbg_sync_r && !evt_internal_halt
        && !evt_vector_catch && !reset_catch && !wr_fire && !monitor_taken
        |=> !hard_fault_req && state_r == ST_RUN && $stable(monitor_pending))
        else $error("dropped event had an effect");
    a_handler_lockup: assert property (clk_en && running && brk_any && !halt_en // R17
        && in_nmi_or_hardfault |=> lockup [*2])
        else $error("breakpoint in handler did not lock up");
    a_vect_no_mon: assert property (clk_en && running && evt_vector_catch && !halt_en // R19
        && !evt_internal_halt && !brk_any && !evt_watchpoint && !edbg_sync_r |-> !to_monitor)
        else $error("vector catch raised monitor");
    a_auth_blocks_halt: assert property (clk_en && !auth_halt_allowed && running // R9
        && !reset_catch |=> !halted)
        else $error("halted without authentication");
endmodule
`default_nettype wire

/* File: tb/debug_agent_model.sv */
/* External debug agent: raises request levels on command.
   Assumes the router's halted output and one clock. */
`timescale 1ns/1ps
`default_nettype none
module debug_agent_model (
    input  wire logic aclk,
    input  wire logic halt_cmd,
    input  wire logic go_cmd,
    input  wire logic halted,
    output logic      dbg_req = 1'b0,
    output logic      rst_req = 1'b0
);
    always @(posedge aclk) begin
        if (halt_cmd)
            dbg_req <= 1'b1;
        else if (halted)
            dbg_req <= 1'b0;
        if (go_cmd)
            rst_req <= 1'b1;
        else if (!halted)
            rst_req <= 1'b0; // Also drops at once when sent while running
    end
endmodule
`default_nettype wire

/* File: tb/debug_event_router_test.sv */
/* Bench for the debug event router and agent model.
   Assumes one 25 MHz clock; bus waits end on the response, or at the hang guard if none comes. */
`timescale 1ns/1ps
`default_nettype none
module debug_event_router_test import debug_event_pkg::*;;
    logic aclk = 0, aresetn = 0, por_resetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, monitor_taken = 0;
    logic in_nmi_or_hardfault = 0, halt_cmd = 0, go_cmd = 0, auth_halt_allowed = 1;
    logic [4:0] ev = 0;
    logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, d;
    logic [7:0] exec_priority = 0, monitor_priority = 8'h10;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic halted, monitor_request, hard_fault_req, lockup, ext_debug_request_in;
    logic ext_restart_request_in;
    int errors = 0, checks = 0, cyc = 0;
    always #20 aclk = ~aclk;
    debug_event_router uut (.aclk, .aresetn, .por_resetn, .clk_en(1'b1), .s_axi_awvalid,
        .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
        .s_axi_wstrb(4'hf), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
        .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
        .s_axi_rresp, .ext_debug_request_in, .ext_restart_request_in,
        .auth_halt_allowed, .exec_priority, .monitor_priority, .in_nmi_or_hardfault,
        .evt_internal_halt(ev[0]), .evt_brk_instr(ev[1]), .evt_brk_unit(ev[2]),
        .evt_watchpoint(ev[3]), .evt_vector_catch(ev[4]), .monitor_taken, .halted,
        .monitor_request, .hard_fault_req, .lockup);
    debug_agent_model agent (.aclk, .halt_cmd, .go_cmd, .halted,
        .dbg_req(ext_debug_request_in), .rst_req(ext_restart_request_in));
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            errors++;
            $display("[FAIL] %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic end_sim;
        if (errors == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Hang guard, far above the run length
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            errors++;
            end_sim();
        end
    end
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        logic b = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= {28'h0, a};
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            b = s_axi_bvalid === 1'b1;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        logic g = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= {28'h0, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!g) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            g = s_axi_rvalid === 1'b1;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // One-cycle event pulse; outputs are settled on return
    task automatic pulse(input logic [4:0] m);
        @(posedge aclk);
        ev <= m;
        @(posedge aclk);
        ev <= 5'h0;
        #1;
    endtask
    task automatic ag(input logic [1:0] c, input logic v);
        @(posedge aclk);
        {halt_cmd, go_cmd} <= c;
        @(posedge aclk);
        {halt_cmd, go_cmd} <= 2'h0;
        for (int i = 0; i < 20 && halted !== v; i++) @(posedge aclk);
        #1;
    endtask
    task automatic lrst;
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        #1;
    endtask
    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic t_catch;
        wr(4'h0, 32'h1);
        wr(4'h4, 32'h1);
        lrst();
        chk("catch", halted, 32'h1);
        rd(4'h0);
        chk("hreq", d & 32'h20002, 32'h20002);
        rd(4'h8);
        chk("vcf", d[3], 32'h1);
    endtask
    task automatic t_ext;
        ag(2'h1, 1'b0);
        chk("restart", halted, 32'h0);
        ag(2'h1, 1'b1);
        chk("run_rst", halted, 32'h0);
        wr(4'h8, 32'h1f);
        auth_halt_allowed <= 1'b0;
        pulse(5'h01);
        chk("auth", halted, 32'h0);
        rd(4'h8);
        chk("ign_flag", d[0], 32'h0);
        auth_halt_allowed <= 1'b1;
        ag(2'h2, 1'b1);
        chk("ext_halt", halted, 32'h1);
        pulse(5'h08);
        rd(4'h8);
        chk("ext_flag", d[4:2], 32'h4);
        rd(4'h0);
        chk("hreq2", d[1], 32'h1);
        ag(2'h1, 1'b0);
    endtask
    task automatic t_mon;
        wr(4'h0, 32'h0);
        wr(4'h4, 32'h10000);
        pulse(5'h08);
        chk("mon", monitor_request, 32'h1);
        rd(4'h8);
        chk("wflag", d[2], 32'h1);
        @(posedge aclk);
        monitor_taken <= 1'b1;
        @(posedge aclk);
        monitor_taken <= 1'b0;
        exec_priority <= 8'h20;
        pulse(5'h08);
        chk("low_w", monitor_request, 32'h0);
        pulse(5'h02);
        chk("hf_instr", hard_fault_req, 32'h1);
        pulse(5'h04);
        chk("hf_unit", hard_fault_req, 32'h1);
        wr(4'h4, 32'h0);
        pulse(5'h02);
        chk("hf_off", hard_fault_req, 32'h1);
        wr(4'h4, 32'h20000);
        chk("sw_pend", monitor_request, 32'h1);
    endtask
    task automatic t_lock;
        in_nmi_or_hardfault <= 1'b1;
        pulse(5'h04);
        chk("lock", lockup, 32'h1);
        lrst();
        chk("unlock", lockup, 32'h0);
        chk("pend_kept", monitor_request, 32'h1);
        rd(4'hc);
        chk("unmap", r, 32'(RESP_SLVERR));
        wr(4'hc, 32'h0);
        chk("wunmap", r, 32'(RESP_SLVERR));
    endtask
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        por_resetn <= 1'b1;
        t_catch();
        t_ext();
        t_mon();
        t_lock();
        end_sim();
    end
endmodule
`default_nettype wire
